/* File: verilog/rfs_top.sv */
// rfs_top: control of an rs485 fieldbus slave: settings, frame counters, answer decisions,
// character format, bit-rate enable and timeout fault. Assumes an AHB-Lite master on the
// register side and a receiver that delivers one rfs_frame_t pulse per finished frame.
`timescale 1ns/1ps
`default_nettype none
module rfs_top #(
   parameter int          CLK_HZ        = rfs_pkg::CLK_HZ_DEF,
   parameter int          TICKS_PER_SEC = CLK_HZ * rfs_pkg::TICK_PERIOD_S,
   parameter logic [15:0] OWN_BTYPE     = 16'h0e01, // arbitrary value
   parameter logic [15:0] LEG_A_BTYPE   = 16'h0c01, // arbitrary value
   parameter logic [15:0] LEG_B_BTYPE   = 16'h0c02  // arbitrary value
) (
   input  wire logic                  ref_clk,         // 50 mhz system clock
   input  wire logic                  rst_n,           // async reset, active low
   input  wire logic                  hsel,            // ahb slave select
   input  wire logic [31:0]           haddr,           // ahb address
   input  wire logic [1:0]            htrans,          // ahb transfer type
   input  wire logic                  hwrite,          // ahb write
   input  wire logic [2:0]            hsize,           // ahb size, word only
   input  wire logic                  hready,          // ahb bus ready
   input  wire logic [31:0]           hwdata,          // ahb write data
   output logic                       hreadyout,       // ahb slave ready
   output logic                       hresp,           // ahb response, always okay
   output logic [31:0]                hrdata,          // ahb read data
   input  wire logic                  older_host_i,    // strap: older host family
   input  wire rfs_pkg::rfs_frame_t   frame_i,         // received frame report
   output rfs_pkg::rfs_resp_t         resp_o,          // answer decision pulse
   output rfs_pkg::rfs_char_fmt_t     char_fmt_o,      // character framing
   output logic                       bit_tick_o,      // bit-rate enable
   output logic                       proto_ba_o,      // building automation active
   output logic                       legacy_mode_o,   // legacy compat mode active
   output logic                       timeout_fault_o, // fault to the host drive
   output logic [15:0]                board_type_o     // board type shown to host
);
   // reset synchroniser
   logic rst_meta_q;
   logic rst_sync_q;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end

   // strap caught once after release, never through the async reset path
   logic strap_done_q;
   logic strap_q;

   always_ff @(posedge ref_clk or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         strap_done_q <= 1'b0;
         strap_q      <= 1'b0;
      end else if (!strap_done_q) begin
         strap_done_q <= 1'b1;
         strap_q      <= older_host_i;
      end
   end

   // bus address phase
   logic       wr_pend_q;
   logic [7:0] wr_addr_q;
   wire        addr_take = hsel & hready & htrans[1];
   wire        rd_take   = addr_take & ~hwrite;
   wire  [7:0] a_off     = {haddr[7:2], 2'b00};

   always_ff @(posedge ref_clk or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= '0;
         hreadyout <= 1'b0;
         hresp     <= 1'b0;
      end else begin
         wr_pend_q <= addr_take & hwrite;
         wr_addr_q <= a_off;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

   // settings
   logic [1:0]  proto_q;
   logic [1:0]  mode_q;
   logic [1:0]  parity_q;
   logic [3:0]  baud_q;
   logic [1:0]  btype_q;
   logic [7:0]  slave_q;
   logic [15:0] timeout_q;
   logic [15:0] fault_code_q;

   wire wr_ctrl  = wr_pend_q & (wr_addr_q == rfs_pkg::REG_CTRL);
   wire wr_slave = wr_pend_q & (wr_addr_q == rfs_pkg::REG_SLAVE);
   wire wr_tmo   = wr_pend_q & (wr_addr_q == rfs_pkg::REG_TIMEOUT);
   wire wr_clr   = wr_pend_q & (wr_addr_q == rfs_pkg::REG_CNT_CLR) & hwdata[0];
   wire wr_fault = wr_pend_q & (wr_addr_q == rfs_pkg::REG_FAULT);

   wire [1:0] w_proto  = hwdata[rfs_pkg::CTRL_PROTO_LSB  +: 2];
   wire [1:0] w_mode   = hwdata[rfs_pkg::CTRL_MODE_LSB   +: 2];
   wire [1:0] w_parity = hwdata[rfs_pkg::CTRL_PARITY_LSB +: 2];
   wire [3:0] w_baud   = hwdata[rfs_pkg::CTRL_BAUD_LSB   +: 4];
   wire [1:0] w_btype  = hwdata[rfs_pkg::CTRL_BTYPE_LSB  +: 2];
   wire [7:0] w_slave  = hwdata[7:0];

   // an illegal code in a field leaves that field unchanged
   wire ok_proto = (w_proto == rfs_pkg::PROTO_MODBUS) | (w_proto == rfs_pkg::PROTO_BA);
   wire ok_mode  = (w_mode == rfs_pkg::MODE_NORMAL) | (w_mode == rfs_pkg::MODE_LEGACY);
   wire ok_baud  = (w_baud >= rfs_pkg::BAUD_MIN) & (w_baud <= rfs_pkg::BAUD_MAX);
   wire ok_btype = (w_btype != 2'h3);
   wire ok_slave = (w_slave >= rfs_pkg::ADDR_MIN) & (w_slave <= rfs_pkg::ADDR_MAX);

   always_ff @(posedge ref_clk or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         proto_q      <= rfs_pkg::PROTO_MODBUS;
         mode_q       <= rfs_pkg::MODE_NORMAL;
         parity_q     <= rfs_pkg::PAR_NONE_2S;
         baud_q       <= rfs_pkg::BAUD_DEF;
         btype_q      <= rfs_pkg::BTYPE_OWN;
         slave_q      <= rfs_pkg::ADDR_MIN;
         timeout_q    <= rfs_pkg::TIMEOUT_DEF;
         fault_code_q <= '0;
      end else begin
         if (wr_ctrl && ok_proto) begin
            proto_q <= w_proto;
         end
         if (wr_ctrl && ok_mode) begin
            mode_q <= w_mode;
         end
         if (wr_ctrl) begin
            parity_q <= w_parity;
         end
         if (wr_ctrl && ok_baud) begin
            baud_q <= w_baud;
         end
         if (wr_ctrl && ok_btype) begin
            btype_q <= w_btype;
         end
         if (wr_slave && ok_slave) begin
            slave_q <= w_slave;
         end
         if (wr_tmo) begin
            timeout_q <= hwdata[15:0];
         end
         if (wr_fault) begin
            fault_code_q <= hwdata[15:0];
         end
      end
   end

   // derived operating state
   wire legacy = strap_q | (mode_q == rfs_pkg::MODE_LEGACY);
   wire is_ba  = (proto_q == rfs_pkg::PROTO_BA);

   // frame classification
   wire good_ev  = frame_i.valid & ~frame_i.corrupt;
   wire err_ev   = frame_i.valid &  frame_i.corrupt;
   wire own_hit  = good_ev & (frame_i.addr == slave_q);
   wire bcast    = good_ev & (frame_i.addr == rfs_pkg::ADDR_BCAST);
   wire items_ok = (frame_i.multi && legacy) ? (frame_i.items_ok != 4'h0)
                                             : (frame_i.items_fail == 4'h0);
   wire flt_hit  = ~is_ba & legacy & frame_i.reg_read &
                   (frame_i.reg_addr == rfs_pkg::FAULT_REG_NO);
   wire exc_hit  = ~is_ba & ~flt_hit & ~items_ok;

   // counters, saturating at the displayed limits
   logic [6:0] err_cnt_q;
   logic [9:0] good_cnt_q;
   wire  [6:0] err_inc  = (err_cnt_q  == rfs_pkg::ERR_MAX)  ? err_cnt_q  : err_cnt_q + 7'h01;
   wire  [9:0] good_inc = (good_cnt_q == rfs_pkg::GOOD_MAX) ? good_cnt_q : good_cnt_q + 10'h001;
   wire  [6:0] err_base  = wr_clr ? 7'h00  : err_cnt_q;
   wire  [9:0] good_base = wr_clr ? 10'h000 : good_cnt_q;

   // an event in the clearing cycle counts as the first after the clear
   always_ff @(posedge ref_clk or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         err_cnt_q  <= '0;
         good_cnt_q <= '0;
      end else begin
         err_cnt_q  <= err_ev  ? (wr_clr ? 7'h01  : err_inc)  : err_base;
         good_cnt_q <= good_ev ? (wr_clr ? 10'h001 : good_inc) : good_base;
      end
   end

   // answer decision: corrupted frames are never parsed further
   always_ff @(posedge ref_clk or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         resp_o <= '0;
      end else begin
         resp_o.respond    <= own_hit;
         resp_o.act        <= own_hit | bcast;
         resp_o.exc        <= own_hit & exc_hit;
         resp_o.exc_code   <= (own_hit & exc_hit) ? rfs_pkg::EXC_BAD_ADDR : 8'h00;
         resp_o.fault_read <= own_hit & flt_hit;
         resp_o.fault_data <= (own_hit & flt_hit) ? fault_code_q : 16'h0000;
      end
   end

   // character format and mode outputs
   wire fmt_par_en  = (parity_q == rfs_pkg::PAR_EVEN) | (parity_q == rfs_pkg::PAR_ODD);
   wire fmt_par_odd = (parity_q == rfs_pkg::PAR_ODD);
   wire fmt_two     = ~is_ba & (parity_q == rfs_pkg::PAR_NONE_2S);
   wire [15:0] btype_val = (btype_q == rfs_pkg::BTYPE_LEG_A) ? LEG_A_BTYPE :
                           (btype_q == rfs_pkg::BTYPE_LEG_B) ? LEG_B_BTYPE :
                                                               OWN_BTYPE;

   always_ff @(posedge ref_clk or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         char_fmt_o    <= '0;
         proto_ba_o    <= 1'b0;
         legacy_mode_o <= 1'b0;
         board_type_o  <= OWN_BTYPE;
      end else begin
         char_fmt_o.parity_en  <= fmt_par_en;
         char_fmt_o.parity_odd <= fmt_par_odd;
         char_fmt_o.two_stop   <= fmt_two;
         proto_ba_o            <= is_ba;
         legacy_mode_o         <= legacy;
         board_type_o          <= btype_val;
      end
   end

   // bit rate follows the code as set; 9600 under building automation is the
   // configuring party's duty, so nothing is forced here
   rfs_baud_gen #(
      .CLK_HZ (CLK_HZ)
   ) u_baud (
      .clk   (ref_clk),
      .rst_n (rst_sync_q),
      .code  (baud_q),
      .tick  (bit_tick_o)
   );

   logic tmo_armed;

   rfs_timeout #(
      .TICKS_PER_SEC (TICKS_PER_SEC)
   ) u_tmo (
      .clk     (ref_clk),
      .rst_n   (rst_sync_q),
      .kick    (own_hit),
      .limit_s (timeout_q),
      .fault   (timeout_fault_o),
      .armed   (tmo_armed)
   );

   // register read mux, sampled in the address phase
   wire [31:0] rd_ctrl = {18'h0, btype_q, baud_q, 2'h0, parity_q, mode_q, proto_q};
   wire [31:0] rd_stat = {28'h0, is_ba, legacy, tmo_armed, timeout_fault_o};
   wire [31:0] rd_comm = {6'h0, good_cnt_q, 9'h0, err_cnt_q};
   wire [31:0] rd_mux  =
      (a_off == rfs_pkg::REG_CTRL)      ? rd_ctrl :
      (a_off == rfs_pkg::REG_SLAVE)     ? {24'h0, slave_q} :
      (a_off == rfs_pkg::REG_TIMEOUT)   ? {16'h0, timeout_q} :
      (a_off == rfs_pkg::REG_STATUS)    ? rd_stat :
      (a_off == rfs_pkg::REG_COMM_STAT) ? rd_comm :
      (a_off == rfs_pkg::REG_FAULT)     ? {16'h0, fault_code_q} :
      (a_off == rfs_pkg::REG_BOARD_ID)  ? {16'h0, btype_val} :
      (haddr[31:8] != 24'h0)            ? 32'h0 : 32'h0;

   always_ff @(posedge ref_clk or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         hrdata <= '0;
      end else begin
         hrdata <= rd_take ? rd_mux : 32'h0;
      end
   end
endmodule
`default_nettype wire

/* File: verilog/rfs_pkg.sv */
// rfs_pkg: constants, codes, register map and carrier structs of the rs485 fieldbus slave
// control. Assumes a 32-bit AHB-Lite register bus and a receiver that reports whole frames.
package rfs_pkg;

   localparam int CLK_HZ_DEF    = 50_000_000;
   localparam int TICK_PERIOD_S = 1;

   // register byte offsets
   localparam logic [7:0] REG_CTRL      = 8'h00;
   localparam logic [7:0] REG_SLAVE     = 8'h04;
   localparam logic [7:0] REG_TIMEOUT   = 8'h08;
   localparam logic [7:0] REG_STATUS    = 8'h0c;
   localparam logic [7:0] REG_COMM_STAT = 8'h10;
   localparam logic [7:0] REG_CNT_CLR   = 8'h14;
   localparam logic [7:0] REG_FAULT     = 8'h18;
   localparam logic [7:0] REG_BOARD_ID  = 8'h1c;

   // ctrl field positions, and the good-count position in comm status
   localparam int CTRL_PROTO_LSB  = 0;
   localparam int CTRL_MODE_LSB   = 2;
   localparam int CTRL_PARITY_LSB = 4;
   localparam int CTRL_BAUD_LSB   = 8;
   localparam int CTRL_BTYPE_LSB  = 12;
   localparam int COMM_GOOD_LSB   = 16;

   localparam logic [1:0] PROTO_MODBUS = 2'h1;
   localparam logic [1:0] PROTO_BA     = 2'h2;
   localparam logic [1:0] MODE_NORMAL  = 2'h1;
   localparam logic [1:0] MODE_LEGACY  = 2'h2;
   localparam logic [1:0] PAR_NONE_2S  = 2'h0;
   localparam logic [1:0] PAR_EVEN     = 2'h1;
   localparam logic [1:0] PAR_ODD      = 2'h2;
   localparam logic [1:0] PAR_NONE_1S  = 2'h3;
   localparam logic [1:0] BTYPE_OWN    = 2'h0;
   localparam logic [1:0] BTYPE_LEG_A  = 2'h1;
   localparam logic [1:0] BTYPE_LEG_B  = 2'h2;

   localparam logic [3:0]  BAUD_MIN     = 4'h1;
   localparam logic [3:0]  BAUD_MAX     = 4'hc;
   localparam logic [3:0]  BAUD_DEF     = 4'h6;
   localparam logic [7:0]  ADDR_BCAST   = 8'h00;
   localparam logic [7:0]  ADDR_MIN     = 8'h01;
   localparam logic [7:0]  ADDR_MAX     = 8'hf7;
   localparam logic [15:0] TIMEOUT_DEF  = 16'h000a;
   localparam logic [6:0]  ERR_MAX      = 7'h40;
   localparam logic [9:0]  GOOD_MAX     = 10'h3e7;
   localparam logic [7:0]  EXC_BAD_ADDR = 8'h02;
   localparam logic [15:0] FAULT_REG_NO = 16'h0062;

   typedef struct packed {
      logic        valid;      // one-cycle pulse: frame ended
      logic        corrupt;    // frame failed crc/framing
      logic [7:0]  addr;       // slave address field
      logic        multi;      // multi-item register access
      logic [3:0]  items_ok;   // items the host accepted
      logic [3:0]  items_fail; // items the host refused
      logic        reg_read;   // holding/input register read
      logic [15:0] reg_addr;   // first register number
   } rfs_frame_t;

   typedef struct packed {
      logic        respond;    // transmit an answer
      logic        act;        // carry out the query
      logic        exc;        // answer is an exception
      logic [7:0]  exc_code;
      logic        fault_read; // answer carries the fault code
      logic [15:0] fault_data;
   } rfs_resp_t;

   typedef struct packed {
      logic parity_en;
      logic parity_odd;
      logic two_stop;
   } rfs_char_fmt_t;

   function automatic int rfs_baud_bps(input logic [3:0] code);
      case (code)
         4'h1:    return 300;
         4'h2:    return 600;
         4'h3:    return 1200;
         4'h4:    return 2400;
         4'h5:    return 4800;
         4'h6:    return 9600;
         4'h7:    return 19200;
         4'h8:    return 38400;
         4'h9:    return 57600;
         4'ha:    return 76800;
         4'hb:    return 115200;
         4'hc:    return 230400;
         default: return 9600;
      endcase
   endfunction

endpackage

/* File: verilog/rfs_baud_gen.sv */
// rfs_baud_gen: one-cycle bit-rate enable from the system clock, selected by baud code.
// Assumes the code is already legal; illegal codes never reach here.
`timescale 1ns/1ps
`default_nettype none
module rfs_baud_gen #(
   parameter int CLK_HZ = rfs_pkg::CLK_HZ_DEF,
   parameter int DIV_W  = 18
) (
   input  wire logic       clk,     // system clock
   input  wire logic       rst_n,   // synchronised reset, active low
   input  wire logic [3:0] code,    // baud code 1..12
   output logic            tick     // one pulse per bit time
);
   logic [DIV_W-1:0] div_tab [1:12];
   logic [DIV_W-1:0] cnt_q;
   logic [DIV_W-1:0] limit;
   logic [3:0]       code_q;

   if ((CLK_HZ / rfs_pkg::rfs_baud_bps(rfs_pkg::BAUD_MIN)) >= (2 ** DIV_W)) begin : g_chk
      $error("rfs_baud_gen: DIV_W too small for the slowest rate");
   end

   // divisors rounded to nearest so the fast rates stay within tolerance
   for (genvar g = 1; g <= 12; g++) begin : g_div
      assign div_tab[g] = DIV_W'((CLK_HZ + rfs_pkg::rfs_baud_bps(4'(g)) / 2) /
                                 rfs_pkg::rfs_baud_bps(4'(g)));
   end

   assign limit = div_tab[code] - DIV_W'(1);

   // a code change restarts the bit period so no stretched bit appears
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q  <= '0;
         tick   <= 1'b0;
         code_q <= rfs_pkg::BAUD_DEF;
      end else begin
         code_q <= code;
         tick   <= (cnt_q == limit) && (code_q == code);
         cnt_q  <= ((cnt_q == limit) || (code_q != code)) ? '0 : cnt_q + DIV_W'(1);
      end
   end
endmodule
`default_nettype wire

/* File: verilog/rfs_timeout.sv */
// rfs_timeout: communication-timeout monitor counting whole seconds since the last own request.
// Assumes kick is a one-cycle pulse per valid request addressed to this slave.
`timescale 1ns/1ps
`default_nettype none
module rfs_timeout #(
   parameter int TICKS_PER_SEC = rfs_pkg::CLK_HZ_DEF * rfs_pkg::TICK_PERIOD_S
) (
   input  wire logic        clk,       // system clock
   input  wire logic        rst_n,     // synchronised reset, active low
   input  wire logic        kick,      // own valid request seen
   input  wire logic [15:0] limit_s,   // timeout in seconds, zero disables
   output logic             fault,     // timeout fault level
   output logic             armed      // first request has been seen
);
   localparam int PW = $clog2(TICKS_PER_SEC + 1);

   logic [PW-1:0] pre_q;
   logic [15:0]   sec_q;
   logic          sec_tick;

   if (TICKS_PER_SEC < 2) begin : g_chk
      $error("rfs_timeout: TICKS_PER_SEC must be at least 2");
   end

   assign sec_tick = (pre_q == PW'(TICKS_PER_SEC - 1));

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pre_q <= '0;
         sec_q <= '0;
         armed <= 1'b0;
         fault <= 1'b0;
      end else begin
         if (kick) begin
            armed <= 1'b1;
            pre_q <= '0;
            sec_q <= '0;
            fault <= 1'b0;
         end else begin
            pre_q <= sec_tick ? '0 : pre_q + PW'(1);
            // a limit lowered below the running count still faults at once
            if (sec_tick && armed && (sec_q < limit_s)) begin
               sec_q <= sec_q + 16'h0001;
            end
            // zero limit holds the fault low
            fault <= (limit_s != 16'h0000) && armed &&
                     (fault || (sec_q >= limit_s));
         end
      end
   end
endmodule
`default_nettype wire

/* File: sim/rfs_top_props.sv */
// rfs_top_props: port checker for rfs_top.
// Assumes it is bound to rfs_top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module rfs_top_props (
   input wire logic                   ref_clk,        // system clock
   input wire logic                   rst_n,          // reset, active low
   input wire logic                   hreadyout,      // slave ready
   input wire rfs_pkg::rfs_frame_t    frame_i,        // frame report
   input wire rfs_pkg::rfs_resp_t     resp_o,         // answer pulse
   input wire rfs_pkg::rfs_char_fmt_t char_fmt_o,     // framing
   input wire logic                   proto_ba_o,     // protocol select
   input wire logic                   legacy_mode_o,  // legacy mode
   input wire logic                   timeout_fault_o // timeout fault
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   wire good_f = frame_i.valid & !frame_i.corrupt;
   property p_corrupt;
      frame_i.valid && frame_i.corrupt |=> !resp_o.act && !resp_o.respond;
   endproperty
   property p_quiet;
      !frame_i.valid |=> !resp_o.respond && !resp_o.act;
   endproperty
   property p_bcast;
      good_f && frame_i.addr == 8'h00 |=> resp_o.act && !resp_o.respond;
   endproperty
   property p_exc;
      resp_o.exc |-> resp_o.respond && resp_o.exc_code == 8'h02 && !proto_ba_o;
   endproperty
   property p_fread;
      resp_o.fault_read |-> legacy_mode_o && !resp_o.exc;
   endproperty
   property p_stop;
      proto_ba_o && $past(proto_ba_o) |-> !char_fmt_o.two_stop;
   endproperty
   property p_par;
      !(char_fmt_o.two_stop && char_fmt_o.parity_en) &&
      !(char_fmt_o.parity_odd && !char_fmt_o.parity_en);
   endproperty
   property p_proto_def;
      $rose(hreadyout) |-> !proto_ba_o && !timeout_fault_o;
   endproperty
   a_corrupt: assert property (p_corrupt) else $error("corrupt frame acted on");
   a_quiet: assert property (p_quiet) else $error("answer without query");
   a_bcast: assert property (p_bcast) else $error("broadcast handled wrongly");
   a_exc: assert property (p_exc) else $error("bad exception answer");
   a_fread: assert property (p_fread) else $error("fault read outside legacy");
   a_stop: assert property (p_stop) else $error("two stop bits in ba");
   a_par: assert property (p_par) else $error("illegal char format");
   a_proto_def: assert property (p_proto_def) else $error("bad state after reset");
   c_resp: cover property (resp_o.respond);
   c_fread: cover property (resp_o.fault_read);
   c_fault: cover property ($rose(timeout_fault_o));
endmodule
`default_nettype wire

/* File: sim/rfs_master_model.sv */
// rfs_master_model: bus master side, reporting one received frame per send call.
// Assumes send is called on a rising edge of clk.
`timescale 1ns/1ps
`default_nettype none
module rfs_master_model (
   input  wire logic           clk,    // system clock
   output rfs_pkg::rfs_frame_t frame_o // frame report to the slave
);
   initial frame_o = '0;
   // only the master starts; fields are scrambled after the pulse, not held
   task automatic send(input logic c, input logic [7:0] a, input logic m,
                       input logic [3:0] ok, input logic [3:0] fl, input logic [15:0] ra);
      rfs_pkg::rfs_frame_t f;
      f = {1'b1, c, a, m, ok, fl, ra != 16'h0, ra};
      @(posedge clk);
      frame_o <= f;
      @(posedge clk);
      f = ~f;
      f.valid = 1'b0;
      frame_o <= f;
   endtask
endmodule
`default_nettype wire

/* File: sim/tb_rs485_fieldbus_slave_control.sv */
// tb_rs485_fieldbus_slave_control: register, frame, format, baud and timeout tests.
// Assumes rfs_top with shortened seconds and a reduced clock figure for baud divisors.
`timescale 1ns/1ps
`default_nettype none
module tb_rs485_fieldbus_slave_control;
   localparam int CLK = 2_304_000;
   logic ref_clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, older = 1'b0;
   logic [31:0] haddr = '0, hwdata = '0, r, hrdata;
   logic [1:0]  htrans = '0;
   logic [2:0]  hsize = 3'h2;
   logic        hreadyout, hresp, tick, ba, leg, flt;
   logic [15:0] btype;
   rfs_pkg::rfs_frame_t    frame;
   rfs_pkg::rfs_resp_t     resp;
   rfs_pkg::rfs_char_fmt_t fmt;
   int errors = 0, num_checks = 0, n, p;
   int bps[12] = '{300, 600, 1200, 2400, 4800, 9600, 19200, 38400, 57600, 76800, 115200, 230400};
   initial forever #10 ref_clk = ~ref_clk;
   rfs_top #(.CLK_HZ(CLK), .TICKS_PER_SEC(20)) u_rfs_top (.ref_clk(ref_clk), .rst_n(rst_n),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hready(hreadyout), .hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .older_host_i(older), .frame_i(frame), .resp_o(resp), .char_fmt_o(fmt),
      .bit_tick_o(tick), .proto_ba_o(ba), .legacy_mode_o(leg), .timeout_fault_o(flt),
      .board_type_o(btype));
   rfs_master_model u_rfs_master_model (.clk(ref_clk), .frame_o(frame));
   task automatic results;
      if (errors == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic tmo(input int k, input int lim);
      if (k >= lim) begin
         errors++;
         $display("mismatch at %0t: wait timed out", $time);
         results();
      end
   endtask
   task automatic wait_rdy;
      for (int i = 0; i < 40; i++) begin
         @(posedge ref_clk);
         if (hreadyout === 1'b1) return;
      end
      errors++;
      $display("mismatch at %0t: no ready", $time);
      results();
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      wait_rdy();
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
      r = hrdata;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(r, e);
      chk(hresp, 32'h0);
   endtask
   // two edges let registered outputs follow the stored value
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
      repeat (2) @(posedge ref_clk);
   endtask
   task automatic sf(input logic c, input logic [7:0] a, input logic m, input logic [3:0] ok,
                     input logic [3:0] fl, input logic [15:0] ra, input logic [3:0] e);
      u_rfs_master_model.send(c, a, m, ok, fl, ra);
      #1;
      chk({resp.respond, resp.act, resp.exc, resp.fault_read}, e);
      if (e[0]) chk(resp.fault_data, 16'h1234);
      if (e[1]) chk(resp.exc_code, 8'h02);
      @(posedge ref_clk);
   endtask
   task automatic reset_dut;
      rst_n <= 1'b0;
      repeat (3) @(posedge ref_clk);
      rst_n <= 1'b1;
      wait_rdy();
      // registered mode outputs follow the latched strap one edge after ready
      repeat (2) @(posedge ref_clk);
   endtask
   initial begin
      reset_dut();
      rd(8'h00, 32'h605);
      rd(8'h08, 32'ha);
      rd(8'h0c, 32'h0);
      rd(8'h1c, 32'he01);
      rd(8'h20, 32'h0);
      wr(8'h08, 32'h2);
      repeat (60) @(posedge ref_clk);
      chk(flt, 1'b0);
      sf(1'b0, 8'h01, 1'b0, 4'h0, 4'h0, 16'h0, 4'b1100);
      sf(1'b0, 8'h02, 1'b0, 4'h0, 4'h0, 16'h0, 4'b0000);
      for (n = 3; n < 60 && flt !== 1'b1; n++) @(posedge ref_clk);
      tmo(n, 60);
      chk(n >= 39 && n <= 42, 1'b1);
      wr(8'h08, 32'h0);
      sf(1'b0, 8'h01, 1'b0, 4'h0, 4'h0, 16'h0, 4'b1100);
      repeat (60) @(posedge ref_clk);
      chk(flt, 1'b0);
      for (int i = 0; i < 4; i++) begin
         wr(8'h00, 32'h605 | (i << 4));
         chk(fmt, 12'b000_110_100_001 >> (i * 3) & 3'h7);
      end
      wr(8'h00, 32'h606);
      chk({ba, fmt.two_stop}, 2'b10);
      wr(8'h00, 32'h605);
      wr(8'h04, 32'h5);
      wr(8'h04, 32'hf8);
      rd(8'h04, 32'h5);
      wr(8'h14, 32'h1);
      sf(1'b0, 8'h05, 1'b0, 4'h0, 4'h0, 16'h0, 4'b1100);
      sf(1'b0, 8'h06, 1'b0, 4'h0, 4'h0, 16'h0, 4'b0000);
      sf(1'b0, 8'h00, 1'b0, 4'h0, 4'h0, 16'h0, 4'b0100);
      sf(1'b1, 8'h05, 1'b0, 4'h0, 4'h0, 16'h0, 4'b0000);
      sf(1'b0, 8'h05, 1'b1, 4'h1, 4'h1, 16'h0, 4'b1110);
      rd(8'h10, 32'h0004_0001);
      wr(8'h00, 32'h609);
      wr(8'h18, 32'h1234);
      sf(1'b0, 8'h05, 1'b1, 4'h1, 4'h1, 16'h0, 4'b1100);
      sf(1'b0, 8'h05, 1'b1, 4'h0, 4'h2, 16'h0, 4'b1110);
      sf(1'b0, 8'h05, 1'b0, 4'h0, 4'h0, 16'h62, 4'b1101);
      rd(8'h0c, 32'h6);
      wr(8'h00, 32'h1609);
      chk(btype, 16'hc01);
      wr(8'h00, 32'h2609);
      rd(8'h1c, 32'hc02);
      for (int i = 0; i < 12; i++) begin
         wr(8'h00, 32'h5 | ((i + 1) << 8));
         for (n = 0; n < 9000 && tick !== 1'b1; n++) @(posedge ref_clk);
         tmo(n, 9000);
         @(posedge ref_clk);
         for (p = 1; p < 9000 && tick !== 1'b1; p++) @(posedge ref_clk);
         tmo(p, 9000);
         chk(p, CLK / bps[i]);
      end
      older <= 1'b1;
      reset_dut();
      chk(leg, 1'b1);
      rd(8'h00, 32'h605);
      results();
   end
endmodule
bind rfs_top rfs_top_props u_rfs_top_props (.ref_clk(ref_clk), .rst_n(rst_n),
   .hreadyout(hreadyout), .frame_i(frame_i), .resp_o(resp_o), .char_fmt_o(char_fmt_o),
   .proto_ba_o(proto_ba_o), .legacy_mode_o(legacy_mode_o), .timeout_fault_o(timeout_fault_o));
`default_nettype wire
